// ### verilog/lae_consts.svh
// Named constants of the load align and extend unit.
// Assumes inclusion by bare name from files on the include path.
`ifndef LAE_CONSTS_SVH
`define LAE_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define LAE_ADDR_CTRL 4'h0
`define LAE_ADDR_STATUS 4'h4
`define LAE_ADDR_MASK 4'h8
`define LAE_ADDR_LASTVA 4'hC

// ****************************************
// Control fields
// ****************************************
`define LAE_CTRL_MEMBE 0
`define LAE_CTRL_CPUBE 1
`define LAE_CTRL_REVE 2
`define LAE_CTRL_MODE64 3
`define LAE_CTRL_PRIV_LO 4
`define LAE_CTRL_PRIV_HI 5
`define LAE_CTRL_RESET 32'h0000_0000
`define LAE_CTRL_MASKW 32'h0000_003F

// ****************************************
// Status and mask fields
// ****************************************
`define LAE_EV_ADDR 0
`define LAE_EV_RSVD 1
`define LAE_EV_FAULT 2
`define LAE_EV_DONE 3
`define LAE_EV_W 4
`define LAE_EV_ZERO 4'h0

// ****************************************
// Privilege encodings and access types
// ****************************************
`define LAE_PRIV_KERNEL 2'h0
`define LAE_TYPE_HALF 3'h1
`define LAE_TYPE_WORD 3'h3
`define LAE_TYPE_DWORD 3'h7
`define LAE_IMM_W 16
`define LAE_BYTE_W 8
`define LAE_ZERO_REG 5'h00

`endif

// ### verilog/lae_pkg.sv
// Types shared by the load align and extend unit and its shaper.
// Assumes nothing of its surroundings.
package lae_pkg;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [2:0] {
    LAE_OP_LOAD_DWORD_RIGHT = 3'h0,
    LAE_OP_LOAD_HALF_SIGNED = 3'h1,
    LAE_OP_LOAD_HALF_UNSIGNED = 3'h2,
    LAE_OP_LOAD_UPPER_IMMEDIATE = 3'h3,
    LAE_OP_LOAD_WORD = 3'h4
  } lae_op_t;

  // ****************************************
  // Exception causes
  // ****************************************
  typedef enum logic [1:0] {
    LAE_EXC_NONE = 2'h0,
    LAE_EXC_ADDRESS = 2'h1,
    LAE_EXC_RESERVED = 2'h2,
    LAE_EXC_FAULT = 2'h3
  } lae_exc_t;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [0:0] {
    LAE_ST_IDLE = 1'b0,
    LAE_ST_WAIT = 1'b1
  } lae_state_t;

endpackage

// ### verilog/lae_shaper.sv
// Combinational merge and extension of returned load data.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/100ps
`default_nettype none
`include "lae_consts.svh"

module lae_shaper (
  input wire lae_pkg::lae_op_t op,
  input wire logic [2:0] vaLow,
  input wire logic cpuBigEndian,
  input wire logic mode64,
  input wire logic [63:0] targetVal,
  input wire logic [63:0] memData,
  input wire logic [15:0] immed,
  output logic [63:0] result
);

  // ****************************************
  // Byte picker
  // ****************************************
  function automatic logic [7:0] pickByte(
    input logic [63:0] d,
    input logic [2:0] k
  );
    logic [63:0] s;
    s = d >> {k, 3'h0};
    return s[7:0];
  endfunction

  // ****************************************
  // Right partial doubleword merge
  // ****************************************
  logic [2:0] drByte;
  logic [63:0] drMerged;
  assign drByte = vaLow ^ {3{cpuBigEndian}};

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : gLane
      localparam logic [3:0] LANE = 4'(i);
      logic [3:0] src;
      assign src = LANE + {1'b0, drByte};
      // Lanes past the doubleword keep the old register bytes
      assign drMerged[i*8 +: 8] = src[3] ? targetVal[i*8 +: 8]
        : pickByte(memData, src[2:0]);
    end
  endgenerate

  // ****************************************
  // Halfword and word selection
  // ****************************************
  logic [2:0] hByte;
  logic [2:0] wByte;
  logic [63:0] hShift;
  logic [63:0] wShift;
  logic [15:0] half;
  logic [31:0] word;
  logic [31:0] upper;
  assign hByte = vaLow ^ {cpuBigEndian, cpuBigEndian, 1'b0};
  assign wByte = vaLow ^ {cpuBigEndian, 2'b00};
  assign hShift = memData >> {hByte, 3'h0};
  assign wShift = memData >> {wByte, 3'h0};
  assign half = hShift[15:0];
  assign word = wShift[31:0];
  assign upper = {immed, {`LAE_IMM_W{1'b0}}};

  // ****************************************
  // Result selection
  // ****************************************
  // In 32-bit mode the upper word is not architecturally visible
  always_comb begin
    case (op)
      lae_pkg::LAE_OP_LOAD_DWORD_RIGHT: result = drMerged;
      lae_pkg::LAE_OP_LOAD_HALF_SIGNED: begin
        result = {{48{half[15]}}, half};
        if (!mode64) begin
          result[63:32] = 32'h0000_0000;
        end
      end
      lae_pkg::LAE_OP_LOAD_HALF_UNSIGNED: result = {48'h0, half};
      lae_pkg::LAE_OP_LOAD_UPPER_IMMEDIATE:
        result = {mode64 ? {32{upper[31]}} : 32'h0000_0000, upper};
      lae_pkg::LAE_OP_LOAD_WORD:
        result = {mode64 ? {32{word[31]}} : 32'h0000_0000, word};
      default: result = targetVal;
    endcase
  end

endmodule
`default_nettype wire

// ### verilog/lae_load_unit.sv
// Load align and extend unit: address, checks, memory request, merge.
// Assumes a translation and memory path answering with memAck.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "lae_consts.svh"

module lae_load_unit (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic irq,
  input wire logic reqValid,
  output logic reqReady,
  input wire lae_pkg::lae_op_t reqOp,
  input wire logic [63:0] baseVal,
  input wire logic [15:0] offset,
  input wire logic [4:0] targetIdx,
  input wire logic [63:0] targetVal,
  output logic memReq,
  output logic [63:0] memVaddr,
  output logic [2:0] memType,
  output logic [2:0] memLowAddr,
  input wire logic memAck,
  input wire logic memFault,
  input wire logic [63:0] memData,
  output logic wbValid,
  output logic [4:0] wbIdx,
  output logic [63:0] wbData,
  output logic excValid,
  output lae_pkg::lae_exc_t excCode,
  output logic [63:0] excVaddr
);

  // ****************************************
  // Control register fields
  // ****************************************
  logic [31:0] ctrl_q;
  logic memBigEndian;
  logic cpuBigEndian;
  logic reverse_endian_flag;
  logic mode64;
  logic [1:0] privMode;
  assign memBigEndian = ctrl_q[`LAE_CTRL_MEMBE];
  assign cpuBigEndian = ctrl_q[`LAE_CTRL_CPUBE];
  assign reverse_endian_flag = ctrl_q[`LAE_CTRL_REVE];
  assign mode64 = ctrl_q[`LAE_CTRL_MODE64];
  assign privMode = ctrl_q[`LAE_CTRL_PRIV_HI:`LAE_CTRL_PRIV_LO];

  // ****************************************
  // Sequencer state
  // ****************************************
  lae_pkg::lae_state_t state_q;
  lae_pkg::lae_op_t op_q;
  logic [4:0] idx_q;
  logic [63:0] tgt_q;
  logic [15:0] imm_q;
  logic [2:0] vaLow_q;

  // Requests are only taken between loads, so no reordering occurs
  assign reqReady = (state_q == lae_pkg::LAE_ST_IDLE);

  logic take;
  assign take = reqValid && reqReady;

  // ****************************************
  // Forwarding of the last written target
  // ****************************************
  logic fwdValid_q;
  logic [4:0] fwdIdx_q;
  logic [63:0] fwdVal_q;
  logic [63:0] tgtNow;

  // The register file may not hold the value just written yet
  assign tgtNow = (fwdValid_q && fwdIdx_q == targetIdx)
                  ? fwdVal_q : targetVal;

  // ****************************************
  // Address formation and checks
  // ****************************************
  logic [63:0] virtual_address;
  logic [2:0] va;
  logic [2:0] drByte;
  logic addrErr;
  logic rsvdErr;
  logic isLoadUpper;

  assign virtual_address = baseVal + {{48{offset[15]}}, offset};
  assign va = virtual_address[2:0];
  assign drByte = va ^ {3{cpuBigEndian}};
  assign isLoadUpper = (reqOp == lae_pkg::LAE_OP_LOAD_UPPER_IMMEDIATE);

  always_comb begin
    case (reqOp)
      lae_pkg::LAE_OP_LOAD_HALF_SIGNED,
      lae_pkg::LAE_OP_LOAD_HALF_UNSIGNED: addrErr = va[0];
      lae_pkg::LAE_OP_LOAD_WORD: addrErr = |va[1:0];
      // Any byte address is legal for the right partial form
      lae_pkg::LAE_OP_LOAD_DWORD_RIGHT: addrErr = 1'b0;
      default: addrErr = 1'b0;
    endcase
  end

  assign rsvdErr = (reqOp == lae_pkg::LAE_OP_LOAD_DWORD_RIGHT)
                   && !mode64
                   && (privMode != `LAE_PRIV_KERNEL);

  // ****************************************
  // Access type and low physical address bits
  // ****************************************
  logic [2:0] accType;
  logic [2:0] lowAddr;

  always_comb begin
    case (reqOp)
      lae_pkg::LAE_OP_LOAD_DWORD_RIGHT: begin
        accType = `LAE_TYPE_DWORD - drByte;
        // Mirrored index when big-endian CPU and reverse endian differ, zero for big memory
        lowAddr = drByte ^ {3{reverse_endian_flag}};
        if (memBigEndian) begin
          lowAddr = 3'h0;
        end
      end
      lae_pkg::LAE_OP_LOAD_HALF_SIGNED,
      lae_pkg::LAE_OP_LOAD_HALF_UNSIGNED: begin
        accType = `LAE_TYPE_HALF;
        lowAddr = va ^ {reverse_endian_flag, reverse_endian_flag, 1'b0};
      end
      lae_pkg::LAE_OP_LOAD_WORD: begin
        accType = `LAE_TYPE_WORD;
        lowAddr = va ^ {reverse_endian_flag, 2'b00};
      end
      default: begin
        accType = `LAE_TYPE_DWORD;
        lowAddr = 3'h0;
      end
    endcase
  end

  // ****************************************
  // Data shaping
  // ****************************************
  logic [63:0] shaped;
  logic [63:0] shapeMem;

  // Upper immediate shapes in the request cycle without memory
  assign shapeMem = (state_q == lae_pkg::LAE_ST_WAIT) ? memData : 64'h0;

  lae_shaper uShaper (
    .op((state_q == lae_pkg::LAE_ST_WAIT) ? op_q : reqOp),
    .vaLow((state_q == lae_pkg::LAE_ST_WAIT) ? vaLow_q : va),
    .cpuBigEndian(cpuBigEndian),
    .mode64(mode64),
    .targetVal((state_q == lae_pkg::LAE_ST_WAIT) ? tgt_q : tgtNow),
    .memData(shapeMem),
    .immed((state_q == lae_pkg::LAE_ST_WAIT) ? imm_q : offset),
    .result(shaped)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  logic ldFault;
  logic ldDone;
  logic startErr;
  assign ldFault = (state_q == lae_pkg::LAE_ST_WAIT) && memAck && memFault;
  assign ldDone = (state_q == lae_pkg::LAE_ST_WAIT) && memAck && !memFault;
  assign startErr = take && (addrErr || rsvdErr);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= lae_pkg::LAE_ST_IDLE;
    end else begin
      case (state_q)
        lae_pkg::LAE_ST_IDLE: begin
          if (take && !addrErr && !rsvdErr && !isLoadUpper) begin
            state_q <= lae_pkg::LAE_ST_WAIT;
          end
        end
        lae_pkg::LAE_ST_WAIT: begin
          if (memAck) begin
            state_q <= lae_pkg::LAE_ST_IDLE;
          end
        end
        default: state_q <= lae_pkg::LAE_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      op_q <= lae_pkg::LAE_OP_LOAD_WORD;
      idx_q <= `LAE_ZERO_REG;
      tgt_q <= 64'h0;
      imm_q <= 16'h0;
      vaLow_q <= 3'h0;
    end else if (take) begin
      op_q <= reqOp;
      idx_q <= targetIdx;
      tgt_q <= tgtNow;
      imm_q <= offset;
      vaLow_q <= va;
    end
  end

  // ****************************************
  // Memory request
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memReq <= 1'b0;
      memVaddr <= 64'h0;
      memType <= 3'h0;
      memLowAddr <= 3'h0;
    end else begin
      memReq <= take && !addrErr && !rsvdErr && !isLoadUpper;
      if (take) begin
        memVaddr <= virtual_address;
        memType <= accType;
        memLowAddr <= lowAddr;
      end
    end
  end

  // ****************************************
  // Write-back and exceptions
  // ****************************************
  logic wbFire;
  assign wbFire = ldDone || (take && isLoadUpper);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wbValid <= 1'b0;
      wbIdx <= `LAE_ZERO_REG;
      wbData <= 64'h0;
    end else begin
      wbValid <= wbFire;
      if (wbFire) begin
        wbIdx <= ldDone ? idx_q : targetIdx;
        wbData <= shaped;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      excValid <= 1'b0;
      excCode <= lae_pkg::LAE_EXC_NONE;
      excVaddr <= 64'h0;
    end else begin
      excValid <= startErr || ldFault;
      if (startErr) begin
        excCode <= rsvdErr ? lae_pkg::LAE_EXC_RESERVED
                           : lae_pkg::LAE_EXC_ADDRESS;
        excVaddr <= virtual_address;
      end else if (ldFault) begin
        excCode <= lae_pkg::LAE_EXC_FAULT;
        excVaddr <= memVaddr;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fwdValid_q <= 1'b0;
      fwdIdx_q <= `LAE_ZERO_REG;
      fwdVal_q <= 64'h0;
    end else if (wbFire) begin
      fwdValid_q <= 1'b1;
      fwdIdx_q <= ldDone ? idx_q : targetIdx;
      fwdVal_q <= shaped;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic [`LAE_EV_W-1:0] status_q;
  logic [`LAE_EV_W-1:0] mask_q;
  logic [31:0] lastVa_q;
  logic [`LAE_EV_W-1:0] events;

  assign events[`LAE_EV_ADDR] = take && addrErr && !rsvdErr;
  assign events[`LAE_EV_RSVD] = take && rsvdErr;
  assign events[`LAE_EV_FAULT] = ldFault;
  assign events[`LAE_EV_DONE] = wbFire;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `LAE_CTRL_RESET;
    end else if (regWr && regAddr == `LAE_ADDR_CTRL) begin
      ctrl_q <= regWdata & `LAE_CTRL_MASKW;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_q <= `LAE_EV_ZERO;
    end else if (regWr && regAddr == `LAE_ADDR_MASK) begin
      mask_q <= regWdata[`LAE_EV_W-1:0];
    end
  end

  // A new event wins over a write-one clear in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_q <= `LAE_EV_ZERO;
    end else if (regWr && regAddr == `LAE_ADDR_STATUS) begin
      status_q <= (status_q & ~regWdata[`LAE_EV_W-1:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lastVa_q <= 32'h0000_0000;
    end else if (take) begin
      lastVa_q <= virtual_address[31:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        `LAE_ADDR_CTRL: regRdata <= ctrl_q;
        `LAE_ADDR_STATUS: regRdata <= {28'h0, status_q};
        `LAE_ADDR_MASK: regRdata <= {28'h0, mask_q};
        `LAE_ADDR_LASTVA: regRdata <= lastVa_q;
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  assign irq = |(status_q & mask_q);

endmodule
`default_nettype wire

// ### tb/lae_assertions.sv
// Port-level checks of the load align and extend unit.
// Assumes binding to the unit's top module; tracks control by its writes.
`timescale 1ns/100ps
`default_nettype none
`include "lae_consts.svh"

module lae_assertions (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire lae_pkg::lae_op_t reqOp,
  input wire logic [63:0] baseVal,
  input wire logic [15:0] offset,
  input wire logic memReq,
  input wire logic [63:0] memVaddr,
  input wire logic [2:0] memType,
  input wire logic [2:0] memLowAddr,
  input wire logic memAck,
  input wire logic memFault,
  input wire logic wbValid,
  input wire logic excValid,
  input wire lae_pkg::lae_exc_t excCode
);
  logic [63:0] va;
  logic [5:0] ctl_q;
  logic take, isDr, isHalf, isWord, isUpper, legalDr;
  assign va = baseVal + {{48{offset[15]}}, offset};
  assign take = reqValid && reqReady;
  assign isDr = reqOp == lae_pkg::LAE_OP_LOAD_DWORD_RIGHT;
  assign isHalf = reqOp == lae_pkg::LAE_OP_LOAD_HALF_SIGNED
    || reqOp == lae_pkg::LAE_OP_LOAD_HALF_UNSIGNED;
  assign isWord = reqOp == lae_pkg::LAE_OP_LOAD_WORD;
  assign isUpper = reqOp == lae_pkg::LAE_OP_LOAD_UPPER_IMMEDIATE;
  assign legalDr = ctl_q[3] || ctl_q[5:4] == `LAE_PRIV_KERNEL;

  // Control shadow: the checker cannot see the register itself
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl_q <= 6'h00;
    end else if (regWr && regAddr == `LAE_ADDR_CTRL) begin
      ctl_q <= regWdata[5:0];
    end
  end

  // ********
  // Checks
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  upper_imm_a:
  assert property (take && isUpper |=> wbValid && !excValid)
    else $error("upper immediate not written");
  half_align_a:
  assert property (take && isHalf && va[0] |=> excValid && !memReq
    && excCode == lae_pkg::LAE_EXC_ADDRESS) else $error("half misalign");
  word_align_a:
  assert property (take && isWord && va[1:0] != 2'h0 |=> excValid
    && !memReq && excCode == lae_pkg::LAE_EXC_ADDRESS)
    else $error("word misalign");
  right_no_align_a:
  assert property (take && isDr |=> !(excValid
    && excCode == lae_pkg::LAE_EXC_ADDRESS)) else $error("right misalign");
  right_reserved_a:
  assert property (take && isDr && !legalDr |=> excValid && !memReq
    && excCode == lae_pkg::LAE_EXC_RESERVED) else $error("no reserved");
  right_legal_a:
  assert property (take && isDr && legalDr |=> memReq && !excValid)
    else $error("right load not issued");
  mem_virtual_address_a:
  assert property (memReq |-> memVaddr == $past(va))
    else $error("bad virtual address");
  right_type_a:
  assert property (memReq && $past(isDr) |->
    memType == 3'h7 - ($past(va[2:0]) ^ {3{ctl_q[1]}})) else $error("type");
  right_low_a:
  assert property (memReq && $past(isDr) |-> memLowAddr == (ctl_q[0] ?
    3'h0 : $past(va[2:0]) ^ {3{ctl_q[2] ^ ctl_q[1]}})) else $error("low");
  other_type_a:
  assert property (memReq && !$past(isDr) |-> memType == ($past(isWord)
    ? `LAE_TYPE_WORD : `LAE_TYPE_HALF)) else $error("access type");
  fault_exc_a:
  assert property (memAck && memFault && !reqReady |=> excValid
    && !wbValid && excCode == lae_pkg::LAE_EXC_FAULT) else $error("fault");
  ack_wb_a:
  assert property (memAck && !memFault && !reqReady |=> wbValid
    && !excValid) else $error("no write back");

  right_cover: cover property (take && isDr && legalDr);
  fault_cover: cover property (memAck && memFault);
  rsvd_cover: cover property (excValid
    && excCode == lae_pkg::LAE_EXC_RESERVED);
endmodule
`default_nettype wire

// ### tb/lae_mem_model.sv
// Memory access path model: answers one request after a set delay.
// Assumes the bench holds delay and return values during each access.
`timescale 1ns/100ps
`default_nettype none

module lae_mem_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic memReq,
  input wire logic [1:0] delay,
  input wire logic [63:0] retData,
  input wire logic retFault,
  output logic memAck,
  output logic memFault,
  output logic [63:0] memData
);
  logic busy_q;
  logic [1:0] cnt_q;

  // Delay zero answers in the cycle right after the request
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (memReq) begin
      busy_q <= 1'b1;
      cnt_q <= delay;
    end else if (busy_q) begin
      busy_q <= cnt_q != 2'h0;
      cnt_q <= cnt_q - 2'h1;
    end
  end
  assign memAck = busy_q && cnt_q == 2'h0;
  assign memFault = memAck && retFault;
  // Inverted off the answer cycle so stale data never passes
  assign memData = memAck ? retData : ~retData;
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the load align and extend unit.
// Assumes the unit, the memory model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "lae_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end

module tb;
  logic clock, irq, reqReady, memReq, memAck, memFault, wbValid, excValid;
  logic nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, reqValid = 1'b0;
  logic retFault = 1'b0, rdSeen = 1'b0;
  logic [1:0] delay = 2'h0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, rexp, lf = 32'h0000_0013;
  logic [31:0] lastVa = 32'h0;
  logic [63:0] baseVal = 64'h0, targetVal = 64'h0, retData = 64'h0;
  logic [63:0] memVaddr, memData, wbData, excVaddr, lastVal = 64'h0;
  logic [15:0] offset = 16'h0;
  logic [4:0] targetIdx = 5'h00, wbIdx, lastIdx = 5'h00;
  logic [2:0] memType, memLowAddr;
  logic [5:0] ctl = 6'h00;
  logic [71:0] got, expV;
  logic [71:0] resQ[$];
  logic [31:0] rdQ[$];
  lae_pkg::lae_op_t reqOp = lae_pkg::LAE_OP_LOAD_WORD;
  lae_pkg::lae_exc_t excCode;
  int error_cnt = 0, comparisons = 0;

  lae_load_unit lae_load_unit_i (.clock(clock), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq), .reqValid(reqValid),
    .reqReady(reqReady), .reqOp(reqOp), .baseVal(baseVal),
    .offset(offset), .targetIdx(targetIdx), .targetVal(targetVal),
    .memReq(memReq), .memVaddr(memVaddr), .memType(memType),
    .memLowAddr(memLowAddr), .memAck(memAck), .memFault(memFault),
    .memData(memData), .wbValid(wbValid), .wbIdx(wbIdx),
    .wbData(wbData), .excValid(excValid), .excCode(excCode),
    .excVaddr(excVaddr));
  lae_mem_model lae_mem_model_i (.clock(clock), .nrst(nrst),
    .memReq(memReq), .delay(delay), .retData(retData),
    .retFault(retFault), .memAck(memAck), .memFault(memFault),
    .memData(memData));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ********
  // Stimulus
  // ********
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  function automatic logic [63:0] ext(input logic [31:0] v, input logic m);
    return m ? {{32{v[31]}}, v} : {32'h0, v};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    if (a == `LAE_ADDR_CTRL) ctl = d[5:0];
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    rdQ.push_back(e);
    @(posedge clock);
    regRd <= 1'b0;
  endtask

  task automatic ld(input lae_pkg::lae_op_t op, input logic [63:0] b,
      input logic [15:0] o, input logic [4:0] ix, input logic flt);
    logic [63:0] va, m, tv, t, sh, r;
    logic [2:0] k;
    logic [1:0] ec;
    logic dn;
    va = b + {{48{o[15]}}, o};
    lastVa = va[31:0];
    m = {rnd(), rnd()};
    tv = {rnd(), rnd()};
    t = (ix == lastIdx) ? lastVal : tv;
    ec = 2'h0;
    case (op)
      lae_pkg::LAE_OP_LOAD_DWORD_RIGHT: begin
        k = va[2:0] ^ {3{ctl[1]}};
        r = (m >> 8 * k) | (t & ~(~64'h0 >> 8 * k));
        if (!ctl[3] && ctl[5:4] != 2'h0) ec = 2'h2;
      end
      lae_pkg::LAE_OP_LOAD_HALF_SIGNED,
      lae_pkg::LAE_OP_LOAD_HALF_UNSIGNED: begin
        sh = m >> 8 * (va[2:0] ^ {ctl[1], ctl[1], 1'b0});
        r = op == lae_pkg::LAE_OP_LOAD_HALF_UNSIGNED ? {48'h0, sh[15:0]}
          : ext({{16{sh[15]}}, sh[15:0]}, ctl[3]);
        if (va[0]) ec = 2'h1;
      end
      lae_pkg::LAE_OP_LOAD_UPPER_IMMEDIATE: r = ext({o, 16'h0}, ctl[3]);
      default: begin
        sh = m >> 8 * (va[2:0] ^ {ctl[1], 2'h0});
        r = ext(sh[31:0], ctl[3]);
        if (va[1:0] != 2'h0) ec = 2'h1;
      end
    endcase
    if (ec == 2'h0 && flt && op != lae_pkg::LAE_OP_LOAD_UPPER_IMMEDIATE)
      ec = 2'h3;
    if (ec != 2'h0) resQ.push_back({1'b1, ec, 5'h00, va});
    else begin
      resQ.push_back({1'b0, 2'h0, ix, r});
      lastIdx = ix;
      lastVal = r;
    end
    reqOp <= op;
    baseVal <= b;
    offset <= o;
    targetIdx <= ix;
    targetVal <= tv;
    retData <= m;
    retFault <= flt;
    delay <= 2'(rnd());
    reqValid <= 1'b1;
    dn = 1'b0;
    for (int n = 0; n < 20 && !dn; n++) begin
      @(posedge clock);
      dn = reqReady;
    end
    reqValid <= 1'b0;
    dn = 1'b0;
    for (int n = 0; n < 20 && !dn; n++) begin
      @(posedge clock);
      dn = wbValid || excValid;
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    logic [31:0] v;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd(`LAE_ADDR_CTRL, `LAE_CTRL_RESET);
    rd(`LAE_ADDR_STATUS, 32'h0);
    wr(`LAE_ADDR_CTRL, 32'hFFFF_FFC8);
    rd(`LAE_ADDR_CTRL, 32'h0000_0008);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 200; i++) begin
      v = rnd();
      if (v[1:0] == 2'h0) wr(`LAE_ADDR_CTRL,
        {26'h0, (v[9:8] == 2'h3) ? 2'h2 : v[9:8], v[7:4]});
      ld(lae_pkg::lae_op_t'(v[12:10] % 3'h5), {rnd(), rnd()}, v[31:16],
        5'h01 + 5'(v[14:13]), v[15] & v[2] & v[3]);
    end
    $display("test loads done");
    rd(`LAE_ADDR_LASTVA, lastVa);
    rd(`LAE_ADDR_STATUS, 32'h0000_000F);
    wr(`LAE_ADDR_MASK, 32'h0);
    @(negedge clock);
    `CHK(irq, 1'b0)
    wr(`LAE_ADDR_MASK, 32'h0000_0004);
    @(negedge clock);
    `CHK(irq, 1'b1)
    wr(`LAE_ADDR_STATUS, 32'h0000_0004);
    @(negedge clock);
    `CHK(irq, 1'b0)
    rd(`LAE_ADDR_STATUS, 32'h0000_000B);
    $display("test interrupts done");
    repeat (2) @(posedge clock);
    `CHK(resQ.size(), 0)
    complete_run();
  end

  // ********
  // Checking
  // ********
  always @(posedge clock) begin
    if (rdSeen) begin
      rexp = rdQ.pop_front();
      `CHK(regRdata, rexp)
    end
    rdSeen <= regRd;
    if (nrst && (wbValid || excValid)) begin
      got = excValid ? {1'b1, excCode, 5'h00, excVaddr}
        : {1'b0, 2'h0, wbIdx, wbData};
      expV = resQ.pop_front();
      `CHK(got, expV)
    end
  end

  initial begin
    repeat (10000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
endmodule

bind lae_load_unit lae_assertions lae_assertions_i (.clock(clock),
  .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
  .baseVal(baseVal), .offset(offset), .memReq(memReq),
  .memVaddr(memVaddr), .memType(memType), .memLowAddr(memLowAddr),
  .memAck(memAck), .memFault(memFault), .wbValid(wbValid),
  .excValid(excValid), .excCode(excCode));
`default_nettype wire
